// ===== rtl/irq_ctrl_pkg.sv
// constants and types shared by the interrupt controller files
// Overview of operation
// - any reset clears the global enable and all flags
// - peripheral redirect needs global, source and group enables; pin redirect needs global and pin enables only
// - flags latch events regardless of enables
// - entry flushes, clears global, pushes, shadows, vectors
// - inside service routine flags set, no redirect
// - return pops address, restores context, sets global
// - pending flag taken once global enable returns
// - requests sampled in first quarter phase
// - wake vectors if global set, else continues
// - instruction after sleep executes before vectoring
// - external pin edge detected per edge select
// - valid edge sets pin flag, vector if enabled
// - entry copies working, status, bank, pointers, latch
// - exit restores live registers from shadow copies
// - shadow copies software accessible in bank 31
// - group enable gates all peripheral requests
package irq_ctrl_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned PC_W = 15;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam int unsigned QUARTERS = 4;
  localparam logic [1:0] FIRST_QUARTER = 2'h0;
  localparam logic [4:0] SHADOW_BANK = 5'h1f;
  localparam int unsigned SHADOW_REG_N = 8;
  // shadow index layout inside bank 31
  localparam logic [2:0] SH_WREG = 3'h0;
  localparam logic [2:0] SH_STATUS = 3'h1;
  localparam logic [2:0] SH_BANK = 3'h2;
  localparam logic [2:0] SH_PTR0L = 3'h3;
  localparam logic [2:0] SH_PTR0H = 3'h4;
  localparam logic [2:0] SH_PTR1L = 3'h5;
  localparam logic [2:0] SH_PTR1H = 3'h6;
  localparam logic [2:0] SH_PCLATCH = 3'h7;
  // timeout and powerdown status bits are never shadowed on entry; a bank 31 write can still set them
  localparam logic [7:0] STATUS_SHADOW_MASK = 8'he7;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_ENTRY = 3'b010,
    ST_WAKE = 3'b100
  } ctrl_state_t;
endpackage

// ===== rtl/ext_edge_detect.sv
// edge detector for the external interrupt pin
`timescale 1ns/1ps
`default_nettype none
module ext_edge_detect (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // pin and selection
  input wire logic pin_i,
  input wire logic ext_edge_select_i,
  // result
  output logic edge_o
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [2:0] fill;
    logic hit;
  } edge_state_t;
  edge_state_t st, next_st;

  // synchronise the pin, then compare against last stable level
  always_comb begin
    next_st = st;
    next_st.sync1 = pin_i;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    // no edge until sync and history stages hold real pin samples,
    // so a pin idling high gives no false edge after reset
    next_st.fill = {st.fill[1:0], 1'b1};
    next_st.hit = st.fill[2]
        & (ext_edge_select_i ? (st.sync2 & ~st.prev) : (~st.sync2 & st.prev));
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign edge_o = st.hit;
endmodule // ext_edge_detect
`default_nettype wire

// ===== rtl/irq_ctrl.sv
// interrupt controller with context shadowing for a small core
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl #(
  parameter int unsigned NPERIPH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // core timing and flow
  input wire logic [1:0] quarter_i,
  input wire logic [14:0] pc_i,
  input wire logic return_from_irq_instr_i,
  input wire logic sleeping_i,
  input wire logic wake_instr_done_i,
  // enables from software
  input wire logic gie_set_i,
  input wire logic gie_clr_i,
  input wire logic periph_group_irq_enable_i,
  input wire logic ext_pin_irq_enable_i,
  input wire logic ext_edge_select_i,
  input wire logic [NPERIPH-1:0] source_enable_bits_i,
  // event sources and flag clears
  input wire logic ext_pin_i,
  input wire logic [NPERIPH-1:0] periph_event_i,
  input wire logic [NPERIPH-1:0] periph_flag_clr_i,
  input wire logic ext_flag_clr_i,
  // live context from core
  input wire logic [7:0] live_reg_i [irq_ctrl_pkg::SHADOW_REG_N],
  // bank 31 shadow access
  input wire logic [4:0] bank_i,
  input wire logic [2:0] sh_addr_i,
  input wire logic sh_we_i,
  input wire logic [7:0] sh_wdata_i,
  output logic [7:0] sh_rdata_o,
  // requests to the core
  output logic global_irq_enable_o,
  output logic flush_o,
  output logic push_o,
  output logic [14:0] push_pc_o,
  output logic load_pc_o,
  output logic [14:0] load_pc_val_o,
  output logic restore_o,
  output logic [7:0] restore_reg_o [irq_ctrl_pkg::SHADOW_REG_N],
  output logic wake_o,
  output logic ext_pin_irq_flag_o,
  output logic [NPERIPH-1:0] periph_flag_o
);
  localparam int unsigned SHADOW_REG_N_L = irq_ctrl_pkg::SHADOW_REG_N;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    irq_ctrl_pkg::ctrl_state_t fsm;
    logic global_irq_enable;
    logic ext_flag;
    logic [NPERIPH-1:0] pflag;
    logic [SHADOW_REG_N_L-1:0][7:0] shadow;
    logic flush;
    logic push;
    logic [14:0] push_pc;
    logic load_pc;
    logic restore;
    logic wake;
    logic [7:0] rdata;
  } ctrl_state_s_t;
  ctrl_state_s_t st, next_st;

  logic ext_edge;
  logic req;

  ext_edge_detect u_edge (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i(ext_pin_i),
    .ext_edge_select_i(ext_edge_select_i),
    .edge_o(ext_edge)
  );

  // request is enabled flags, peripheral group gated, no global gate
  always_comb begin
    req = (st.ext_flag & ext_pin_irq_enable_i)
        | (periph_group_irq_enable_i & |(st.pflag & source_enable_bits_i));
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.flush = 1'b0;
    next_st.push = 1'b0;
    next_st.load_pc = 1'b0;
    next_st.restore = 1'b0;
    next_st.wake = 1'b0;
    // flags: set wins over clear, enables ignored
    next_st.pflag = (st.pflag & ~periph_flag_clr_i) | periph_event_i;
    next_st.ext_flag = (st.ext_flag & ~ext_flag_clr_i) | ext_edge;
    // software global enable control
    if (gie_set_i) begin
      next_st.global_irq_enable = 1'b1;
    end else if (gie_clr_i) begin
      next_st.global_irq_enable = 1'b0;
    end
    // return restores context and re-enables
    if (return_from_irq_instr_i) begin
      next_st.global_irq_enable = 1'b1;
      next_st.restore = 1'b1;
    end
    // software access to shadow copies in bank 31
    if (sh_we_i && bank_i == irq_ctrl_pkg::SHADOW_BANK) begin
      next_st.shadow[sh_addr_i] = sh_wdata_i;
    end
    next_st.rdata = st.shadow[sh_addr_i];
    case (st.fsm)
      irq_ctrl_pkg::ST_RUN: begin
        if (sleeping_i && req) begin
          next_st.wake = 1'b1;
          next_st.fsm = st.global_irq_enable ? irq_ctrl_pkg::ST_WAKE : irq_ctrl_pkg::ST_RUN;
        end else if (!sleeping_i && st.global_irq_enable && req && !return_from_irq_instr_i
                     && quarter_i == irq_ctrl_pkg::FIRST_QUARTER) begin
          next_st.fsm = irq_ctrl_pkg::ST_ENTRY;
        end
      end
      irq_ctrl_pkg::ST_WAKE: begin
        // the instruction after sleep runs first
        if (wake_instr_done_i) begin
          next_st.fsm = irq_ctrl_pkg::ST_ENTRY;
        end
      end
      irq_ctrl_pkg::ST_ENTRY: begin
        next_st.flush = 1'b1;
        next_st.global_irq_enable = 1'b0;
        next_st.push = 1'b1;
        next_st.push_pc = pc_i;
        next_st.load_pc = 1'b1;
        for (int i = 0; i < SHADOW_REG_N_L; i++) begin
          next_st.shadow[i] = live_reg_i[i];
        end
        next_st.shadow[irq_ctrl_pkg::SH_STATUS] =
          live_reg_i[irq_ctrl_pkg::SH_STATUS] & irq_ctrl_pkg::STATUS_SHADOW_MASK;
        next_st.fsm = irq_ctrl_pkg::ST_RUN;
      end
      default: begin
        next_st.fsm = irq_ctrl_pkg::ST_RUN;
      end
    endcase
  end

  // register the state; reset disables everything
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '0;
      st.fsm <= irq_ctrl_pkg::ST_RUN;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign global_irq_enable_o = st.global_irq_enable;
  assign flush_o = st.flush;
  assign push_o = st.push;
  assign push_pc_o = st.push_pc;
  assign load_pc_o = st.load_pc;
  assign load_pc_val_o = irq_ctrl_pkg::IRQ_VECTOR;
  assign restore_o = st.restore;
  assign wake_o = st.wake;
  assign sh_rdata_o = st.rdata;
  assign ext_pin_irq_flag_o = st.ext_flag;
  assign periph_flag_o = st.pflag;
  always_comb begin
    for (int i = 0; i < SHADOW_REG_N_L; i++) begin
      restore_reg_o[i] = st.shadow[i];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_reset_gie_off: assert property (@(posedge clk_i) srst_i |=> !global_irq_enable_o)
    else $error("global enable set after reset");
  a_entry_vector: assert property (@(posedge clk_i) disable iff (srst_i)
    load_pc_o |-> push_o && flush_o && !global_irq_enable_o)
    else $error("entry sequence incomplete");
  a_no_entry_gie_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (st.fsm == irq_ctrl_pkg::ST_RUN && !sleeping_i && !st.global_irq_enable) |=> !load_pc_o)
    else $error("redirect while globally disabled");
  a_flag_latch: assert property (@(posedge clk_i) disable iff (srst_i)
    periph_event_i[0] |=> periph_flag_o[0])
    else $error("event not latched");
  a_return_from_irq_instr_gie: assert property (@(posedge clk_i) disable iff (srst_i)
    return_from_irq_instr_i |=> global_irq_enable_o && restore_o)
    else $error("return did not re-enable");
  a_group_block: assert property (@(posedge clk_i) disable iff (srst_i)
    (!periph_group_irq_enable_i && !(st.ext_flag && ext_pin_irq_enable_i)) |-> !req)
    else $error("peripheral request passed group gate");
  a_ext_flag_edge: assert property (@(posedge clk_i) disable iff (srst_i)
    ext_edge |=> ext_pin_irq_flag_o)
    else $error("edge did not set pin flag");
  a_entry_quarter: assert property (@(posedge clk_i) disable iff (srst_i)
    (st.fsm == irq_ctrl_pkg::ST_RUN && $rose(st.fsm == irq_ctrl_pkg::ST_ENTRY) == 1'b0
     && next_st.fsm == irq_ctrl_pkg::ST_ENTRY && !sleeping_i)
    |-> quarter_i == irq_ctrl_pkg::FIRST_QUARTER)
    else $error("request taken outside first quarter");
  a_status_mask: assert property (@(posedge clk_i) disable iff (srst_i)
    $past(st.fsm == irq_ctrl_pkg::ST_ENTRY) |->
    (restore_reg_o[irq_ctrl_pkg::SH_STATUS] & ~irq_ctrl_pkg::STATUS_SHADOW_MASK) == 8'h00)
    else $error("status shadow kept masked bits");
  // a wake with the global enable off resumes in place, no vector
  a_wake_gie_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (st.fsm == irq_ctrl_pkg::ST_RUN && sleeping_i && req && !st.global_irq_enable)
    |=> wake_o && st.fsm == irq_ctrl_pkg::ST_RUN)
    else $error("wake with global enable off vectored");
  // no redirect until the instruction after sleep has finished
  a_wake_wait: assert property (@(posedge clk_i) disable iff (srst_i)
    (st.fsm == irq_ctrl_pkg::ST_WAKE && !wake_instr_done_i) |=> !load_pc_o && !flush_o)
    else $error("vector before instruction after sleep");
  c_entry: cover property (@(posedge clk_i) load_pc_o);
  c_return: cover property (@(posedge clk_i) restore_o);
  c_wake_vector: cover property (@(posedge clk_i) st.fsm == irq_ctrl_pkg::ST_WAKE);
  c_pin_edge: cover property (@(posedge clk_i) ext_edge);
endmodule // irq_ctrl
`default_nettype wire

// ===== tb/core_model.sv
// core side model: quarter phase sequencer and program counter
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // core timing
  output logic [1:0] quarter_o,
  output logic [14:0] pc_o
);
  // four quarter phases per instruction cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) quarter_o <= 2'h0;
    else quarter_o <= quarter_o + 2'h1;
  end
  assign pc_o = 15'h1234;
endmodule // core_model
`default_nettype wire

// ===== tb/irq_ctrl_test.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_test;
  logic clk_i = 1'b0, srst_i = 1'b1, return_from_irq_instr_i = 1'b0, gie_set_i = 1'b0, gie_clr_i = 1'b0;
  logic sleeping_i = 1'b0, wake_i = 1'b0, grp = 1'b0, ext_en = 1'b0, edge_sel = 1'b1;
  logic ext_pin_i = 1'b0, ext_clr = 1'b0, sh_we_i = 1'b0;
  logic [7:0] en = 8'h00, ev = 8'h00, clr = 8'h00, sh_wdata_i = 8'h00, sh_rdata_o;
  logic [4:0] bank_i = 5'h00;
  logic [2:0] sh_addr_i = 3'h0;
  logic [1:0] quarter;
  logic [14:0] pc, push_pc_o, load_pc_val_o;
  logic [7:0] live [8], rest [8];
  logic gie_o, flush_o, push_o, load_pc_o, restore_o, wake_o, ext_flag;
  logic [7:0] pflag;
  int failures = 0, n_tests = 0, cyc = 0;
  // ************
  // instances
  // ************
  core_model core_u (.clk_i(clk_i), .srst_i(srst_i), .quarter_o(quarter), .pc_o(pc));
  irq_ctrl #(.NPERIPH(8)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .quarter_i(quarter),
    .pc_i(pc), .return_from_irq_instr_i(return_from_irq_instr_i), .sleeping_i(sleeping_i), .wake_instr_done_i(wake_i),
    .gie_set_i(gie_set_i), .gie_clr_i(gie_clr_i), .periph_group_irq_enable_i(grp),
    .ext_pin_irq_enable_i(ext_en), .ext_edge_select_i(edge_sel), .source_enable_bits_i(en),
    .ext_pin_i(ext_pin_i), .periph_event_i(ev), .periph_flag_clr_i(clr),
    .ext_flag_clr_i(ext_clr), .live_reg_i(live), .bank_i(bank_i), .sh_addr_i(sh_addr_i),
    .sh_we_i(sh_we_i), .sh_wdata_i(sh_wdata_i), .sh_rdata_o(sh_rdata_o),
    .global_irq_enable_o(gie_o), .flush_o(flush_o), .push_o(push_o), .push_pc_o(push_pc_o),
    .load_pc_o(load_pc_o), .load_pc_val_o(load_pc_val_o), .restore_o(restore_o),
    .restore_reg_o(rest), .wake_o(wake_o), .ext_pin_irq_flag_o(ext_flag),
    .periph_flag_o(pflag));
  // clock and hang guard
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      summarize();
    end
  end
  // ************
  // helpers
  // ************
  task automatic check(input string name, input logic [14:0] seen, input logic [14:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // wait for flush (0) or restore (1); returns whether it came
  task automatic wait_on(input int which, output logic seen);
    int i;
    seen = 1'b0;
    for (i = 0; i < 20 && !seen; i++) begin
      tick(1);
      seen = (which == 0) ? (flush_o === 1'b1) : (restore_o === 1'b1);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ************
  // scenarios
  // ************
  task automatic t_disabled();
    logic s;
    check("gie after reset", gie_o, 0);
    en = 8'h01;
    ev = 8'h01;
    tick(1);
    ev = 8'h00;
    wait_on(0, s);
    check("flag gie off", pflag, 8'h01);
    check("no entry gie off", s, 0);
    $display("disabled done");
  endtask
  task automatic t_entry();
    logic s;
    gie_set_i = 1'b1;
    tick(1);
    gie_set_i = 1'b0;
    wait_on(0, s);
    check("group blocks", s, 0);
    grp = 1'b1;
    wait_on(0, s);
    check("flush", s, 1);
    check("push", push_o, 1);
    check("load", load_pc_o, 1);
    check("vector", load_pc_val_o, 15'h0004);
    check("push pc", push_pc_o, 15'h1234);
    tick(1);
    check("gie cleared", gie_o, 0);
    $display("entry done");
  endtask
  task automatic t_exit();
    clr = 8'h01;
    live[0] = 8'h99;
    tick(1);
    clr = 8'h00;
    return_from_irq_instr_i = 1'b1;
    tick(1);
    return_from_irq_instr_i = 1'b0;
    // the restore pulse stands for the cycle right after the return
    check("restore", restore_o, 1);
    check("gie set", gie_o, 1);
    check("w restored", rest[0], 8'h10);
    check("status masked", rest[1], 8'hff & irq_ctrl_pkg::STATUS_SHADOW_MASK);
    tick(1);
    check("restore pulse ends", restore_o, 0);
    check("gie stays set", gie_o, 1);
    bank_i = irq_ctrl_pkg::SHADOW_BANK;
    sh_we_i = 1'b1;
    sh_wdata_i = 8'h5a;
    tick(1);
    sh_we_i = 1'b0;
    tick(1);
    check("shadow rw", sh_rdata_o, 8'h5a);
    check("shadow to restore", rest[0], 8'h5a);
    $display("exit done");
  endtask
  task automatic t_pin();
    int e;
    logic s;
    gie_clr_i = 1'b1;
    tick(1);
    gie_clr_i = 1'b0;
    for (e = 1; e >= 0; e--) begin
      edge_sel = e[0];
      ext_clr = 1'b1;
      tick(1);
      ext_clr = 1'b0;
      tick(6);
      check("no flag", ext_flag, 0);
      ext_pin_i = e[0];
      tick(6);
      check("pin flag", ext_flag, 1);
    end
    // pin flag pending with global enable off, then taken once it is set
    ext_en = 1'b1;
    wait_on(0, s);
    check("pin no entry gie off", s, 0);
    gie_set_i = 1'b1;
    tick(1);
    gie_set_i = 1'b0;
    wait_on(0, s);
    check("pin entry", s, 1);
    ext_en = 1'b0;
    ext_clr = 1'b1;
    tick(1);
    ext_clr = 1'b0;
    $display("pin done");
  endtask
  task automatic t_sleep();
    logic s;
    // wake source enabled before the core goes to sleep
    en = 8'h02;
    sleeping_i = 1'b1;
    tick(2);
    check("no wake idle", wake_o, 0);
    ev = 8'h02;
    tick(1);
    ev = 8'h00;
    tick(1);
    check("wake gie off", wake_o, 1);
    sleeping_i = 1'b0;
    wait_on(0, s);
    check("no vector gie off", s, 0);
    clr = 8'h02;
    gie_set_i = 1'b1;
    tick(1);
    clr = 8'h00;
    gie_set_i = 1'b0;
    sleeping_i = 1'b1;
    ev = 8'h02;
    tick(1);
    ev = 8'h00;
    tick(1);
    check("wake gie on", wake_o, 1);
    sleeping_i = 1'b0;
    wait_on(0, s);
    check("next instr first", s, 0);
    wake_i = 1'b1;
    tick(1);
    wake_i = 1'b0;
    wait_on(0, s);
    check("wake vector", s, 1);
    check("sleep shadow", rest[0], 8'h99);
    $display("sleep done");
  endtask
  task automatic t_reset();
    gie_set_i = 1'b1;
    ev = 8'h04;
    tick(1);
    gie_set_i = 1'b0;
    ev = 8'h00;
    check("gie before reset", gie_o, 1);
    srst_i = 1'b1;
    tick(2);
    srst_i = 1'b0;
    tick(2);
    check("gie after mid reset", gie_o, 0);
    check("flags after mid reset", pflag, 8'h00);
    $display("reset done");
  endtask
  initial begin
    foreach (live[i]) live[i] = 8'h10 + 8'(i);
    live[1] = 8'hff;
    tick(10);
    srst_i = 1'b0;
    tick(2);
    t_disabled();
    t_entry();
    t_exit();
    t_pin();
    t_sleep();
    t_reset();
    summarize();
  end
endmodule // irq_ctrl_test
`default_nettype wire
